// ---- rtl/pbsp_core.v ----
// Purpose: byte swapping on port b and parity check/generation on both ports
// Assumes: one clock for both ports; bus sizing, queue storage and mail
//          registers live outside and hand words in and out of this block
// Notes:   pins pass a two flop synchroniser before any logic reads them
`include "pbsp_defines.vh"

// Summary of operation
// R01: swap selects sampled on new long word edge
// R02: latched swap held for rest of long word
// R03: mail data never byte swapped
// R04: four swaps, whole 9-bit bytes only
// R05: swap codes give ABCD, DCBA, CDAB, BADC
// R06: read toward b: swap first, split later
// R07: write from b: assemble first, swap at commit
// R08: four 9-bit parity trees per port
// R09: port a error low on any bad byte
// R10: port b error only on valid lanes
// R11: check sense follows odd/even select
// R12: port a mail read with generate forces high
// R13: port b mail read with generate forces high
// R14: generate puts parity in byte top bit
// R15: writes keep all nine bits as driven
// R16: parity made from low eight bits
// R17: generate between ram read and output load
// R18: far side holds selects stable at load edge
// R19: mail parity reuses trees, contents untouched
// R20: without generate top bit passes unchanged
module pbsp_core (
  input  wire        clock,
  input  wire        rstn,
  // port a pins
  input  wire [35:0] porta_data_in,
  input  wire        porta_chip_sel_n,
  input  wire        porta_xfer_en,
  input  wire        porta_write_not_read,
  input  wire        porta_mail_sel,
  input  wire        porta_parity_gen_sel,
  // port b pins
  input  wire [35:0] portb_data_in,
  input  wire        portb_chip_sel_n,
  input  wire        portb_xfer_en,
  input  wire        portb_write_not_read,
  input  wire        portb_size_sel_hi,
  input  wire        portb_size_sel_lo,
  input  wire        portb_big_endian_n,
  input  wire        portb_parity_gen_sel,
  input  wire        swap_sel_hi,
  input  wire        swap_sel_lo,
  input  wire        odd_even_sel,
  // a_to_b_queue read side and a_to_b_mail_reg contents
  input  wire [35:0] ab_ram_rd_data,
  input  wire        ab_ram_rd_strobe,
  input  wire [35:0] a_to_b_mail_reg,
  // b_to_a_queue write side (assembled long word)
  input  wire [35:0] ba_assembled_word,
  input  wire        ba_word_start,
  input  wire        ba_ram_wr_strobe,
  // b_to_a_queue read side and b_to_a_mail_reg contents
  input  wire [35:0] ba_ram_rd_data,
  input  wire        ba_ram_rd_strobe,
  input  wire [35:0] b_to_a_mail_reg,
  // outputs
  output wire [35:0] portb_data_out,
  output wire [35:0] porta_data_out,
  output wire [35:0] ba_ram_wr_data,
  output wire        ba_ram_wr_valid,
  output wire        porta_parity_err_n,
  output wire        portb_parity_err_n
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // only whole bytes move; bit order in a byte is never touched [R04]
  function [35:0] swap_word;
    input [35:0] w;
    input [1:0]  mode;
    reg   [8:0]  ba;
    reg   [8:0]  bb;
    reg   [8:0]  bc;
    reg   [8:0]  bd;
    begin
      ba = w[35:27];
      bb = w[26:18];
      bc = w[17:9];
      bd = w[8:0];
      case (mode)
        `PBSP_SWAP_NONE: swap_word = {ba, bb, bc, bd}; // [R05]
        `PBSP_SWAP_FULL: swap_word = {bd, bc, bb, ba}; // [R05]
        `PBSP_SWAP_HALF: swap_word = {bc, bd, ba, bb}; // [R05]
        `PBSP_SWAP_PAIR: swap_word = {bb, ba, bd, bc}; // [R05]
        default:         swap_word = w;
      endcase
    end
  endfunction

  // parity bit over the low eight bits; odd sense makes total ones odd
  function par_bit;
    input [7:0] d;
    input       odd;
    begin
      par_bit = odd ? ~(^d) : (^d); // [R16]
    end
  endfunction

  // optional generation: replace or keep each byte top bit
  function [35:0] gen_word;
    input [35:0] w;
    input        gen;
    input        odd;
    integer      i;
    begin
      gen_word = w;
      for (i = 0; i < `PBSP_LANES; i = i + 1) begin
        if (gen) begin
          gen_word[i*9+8] = par_bit(w[i*9 +: 8], odd); // [R14] [R16]
        end else begin
          gen_word[i*9+8] = w[i*9+8]; // [R20]
        end
      end
    end
  endfunction

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  wire [87:0] pin_raw;
  reg  [87:0] pin_meta_ff;
  reg  [87:0] pin_sync_ff;

  assign pin_raw = {porta_data_in, portb_data_in,
                    porta_chip_sel_n, porta_xfer_en, porta_write_not_read,
                    porta_mail_sel, porta_parity_gen_sel,
                    portb_chip_sel_n, portb_xfer_en, portb_write_not_read,
                    portb_size_sel_hi, portb_size_sel_lo, portb_big_endian_n,
                    portb_parity_gen_sel, swap_sel_hi, swap_sel_lo,
                    odd_even_sel, 1'b0};

  // first stage feeds the second stage only
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= `PBSP_RST_SYNC;
      pin_sync_ff <= `PBSP_RST_SYNC;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire [35:0] a_bus    = pin_sync_ff[87:52];
  wire [35:0] b_bus    = pin_sync_ff[51:16];
  wire        a_cs_n   = pin_sync_ff[15];
  wire        a_en     = pin_sync_ff[14];
  wire        a_wnr    = pin_sync_ff[13];
  wire        a_mail   = pin_sync_ff[12];
  wire        a_gen    = pin_sync_ff[11];
  wire        b_cs_n   = pin_sync_ff[10];
  wire        b_en     = pin_sync_ff[9];
  wire        b_wnr    = pin_sync_ff[8];
  wire [1:0]  b_size   = pin_sync_ff[7:6];
  wire        b_be_n   = pin_sync_ff[5];
  wire        b_gen    = pin_sync_ff[4];
  wire [1:0]  swap_pin = pin_sync_ff[3:2];
  wire        odd_sel  = pin_sync_ff[1];

  // ************************************************************
  // mail read decode
  // ************************************************************
  wire a_mail_rd = ~a_cs_n & a_en & ~a_wnr & a_mail;
  wire b_mail_rd = ~b_cs_n & b_en & ~b_wnr & (b_size == `PBSP_SIZE_MAIL);

  // ************************************************************
  // a_to_b_queue read path toward port b
  // ************************************************************
  reg  [1:0]  ab_mode_ff;
  reg  [35:0] ab_out_ff;
  reg  [35:0] b_mail_out_ff;
  reg         b_sel_mail_ff;
  wire [1:0]  nxt_ab_mode;

  // selects only count on the edge that fetches a new long word
  assign nxt_ab_mode = ab_ram_rd_strobe ? swap_pin : ab_mode_ff; // [R01] [R02]

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ab_mode_ff    <= `PBSP_RST_MODE;
      ab_out_ff     <= `PBSP_RST_WORD;
      b_mail_out_ff <= `PBSP_RST_WORD;
      b_sel_mail_ff <= 1'b0;
    end else begin
      ab_mode_ff <= nxt_ab_mode;
      if (ab_ram_rd_strobe) begin
        // swap the whole long word, sizing splits it afterwards [R06]
        // generate/odd sampled only here, on the load edge [R17]
        ab_out_ff <= gen_word(swap_word(ab_ram_rd_data, swap_pin),
                              b_gen, odd_sel);
      end
      if (b_mail_rd) begin
        // mail keeps its byte order; the stored register is only read [R03] [R19]
        b_mail_out_ff <= gen_word(a_to_b_mail_reg, b_gen, odd_sel);
      end
      b_sel_mail_ff <= b_mail_rd;
    end
  end

  assign portb_data_out = b_sel_mail_ff ? b_mail_out_ff : ab_out_ff;

  // ************************************************************
  // b_to_a_queue write path from port b
  // ************************************************************
  reg  [1:0]  ba_mode_ff;
  reg  [35:0] ba_wr_ff;
  reg         ba_wr_valid_ff;
  wire [1:0]  ba_mode_eff;

  // long word size starts and commits on one edge, so take the pins then
  assign ba_mode_eff = ba_word_start ? swap_pin : ba_mode_ff; // [R01] [R02]

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ba_mode_ff     <= `PBSP_RST_MODE;
      ba_wr_ff       <= `PBSP_RST_WORD;
      ba_wr_valid_ff <= 1'b0;
    end else begin
      ba_mode_ff     <= ba_mode_eff;
      ba_wr_valid_ff <= ba_ram_wr_strobe;
      if (ba_ram_wr_strobe) begin
        // assembled word swapped at commit; all nine bits stored [R07] [R15]
        ba_wr_ff <= swap_word(ba_assembled_word, ba_mode_eff);
      end
    end
  end

  assign ba_ram_wr_data  = ba_wr_ff;
  assign ba_ram_wr_valid = ba_wr_valid_ff;

  // ************************************************************
  // b_to_a_queue read path toward port a
  // ************************************************************
  reg  [35:0] ba_out_ff;
  reg  [35:0] a_mail_out_ff;
  reg         a_sel_mail_ff;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ba_out_ff     <= `PBSP_RST_WORD;
      a_mail_out_ff <= `PBSP_RST_WORD;
      a_sel_mail_ff <= 1'b0;
    end else begin
      if (ba_ram_rd_strobe) begin
        ba_out_ff <= gen_word(ba_ram_rd_data, a_gen, odd_sel); // [R17]
      end
      if (a_mail_rd) begin
        a_mail_out_ff <= gen_word(b_to_a_mail_reg, a_gen, odd_sel); // [R19]
      end
      a_sel_mail_ff <= a_mail_rd;
    end
  end

  assign porta_data_out = a_sel_mail_ff ? a_mail_out_ff : ba_out_ff;

  // ************************************************************
  // parity checking
  // ************************************************************
  wire [3:0] a_byte_bad;
  wire [3:0] b_byte_bad;
  reg  [3:0] b_lanes;

  genvar g;
  generate
    for (g = 0; g < `PBSP_LANES; g = g + 1) begin : g_tree
      // odd sense: a byte with an even count of ones is bad [R08] [R11]
      assign a_byte_bad[g] = odd_sel ? ~(^a_bus[g*9 +: 9]) : (^a_bus[g*9 +: 9]);
      assign b_byte_bad[g] = odd_sel ? ~(^b_bus[g*9 +: 9]) : (^b_bus[g*9 +: 9]);
    end
  endgenerate

  // unused lanes of a narrow bus are don't care [R10]
  always @* begin
    case (b_size)
      `PBSP_SIZE_LONG: b_lanes = `PBSP_LANES_ALL;
      `PBSP_SIZE_WORD: b_lanes = b_be_n ? `PBSP_LANES_W_LE : `PBSP_LANES_W_BE;
      `PBSP_SIZE_BYTE: b_lanes = b_be_n ? `PBSP_LANES_B_LE : `PBSP_LANES_B_BE;
      default:         b_lanes = `PBSP_LANES_ALL;
    endcase
  end

  reg a_err_n_ff;
  reg b_err_n_ff;

  // flags idle high from reset, so no false error before the first sample
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      a_err_n_ff <= 1'b1;
      b_err_n_ff <= 1'b1;
    end else begin
      // trees busy generating mail parity, so the flag is held high [R12] [R09]
      a_err_n_ff <= (a_mail_rd & a_gen) ? 1'b1 : ~(|a_byte_bad);
      b_err_n_ff <= (b_mail_rd & b_gen) ? 1'b1 : ~(|(b_byte_bad & b_lanes)); // [R13] [R10]
    end
  end

  assign porta_parity_err_n = a_err_n_ff;
  assign portb_parity_err_n = b_err_n_ff;

endmodule // pbsp_core

// ---- rtl/pbsp_defines.vh ----
// Purpose: constants for the port byte swap and parity block
// Assumes: 36-bit long words made of four 9-bit bytes
// Notes:   included by rtl/pbsp_core.v only
`ifndef PBSP_DEFINES_VH
`define PBSP_DEFINES_VH

// ************************************************************
// word layout
// ************************************************************
`define PBSP_WORD_W      36
`define PBSP_BYTE_W      9
`define PBSP_LANES       4
`define PBSP_PAR_BIT     8
`define PBSP_CTRL_W      16
`define PBSP_SYNC_W      88

// ************************************************************
// swap arrangements, code is {swap_sel_hi, swap_sel_lo}
// ************************************************************
`define PBSP_SWAP_NONE   2'h0
`define PBSP_SWAP_FULL   2'h1
`define PBSP_SWAP_HALF   2'h2
`define PBSP_SWAP_PAIR   2'h3

// ************************************************************
// port b size codes, code is {size_sel_hi, size_sel_lo}
// ************************************************************
`define PBSP_SIZE_LONG   2'h0
`define PBSP_SIZE_WORD   2'h1
`define PBSP_SIZE_BYTE   2'h2
`define PBSP_SIZE_MAIL   2'h3

// ************************************************************
// valid lane masks, bit n is lane n (lane 3 is bits 35..27)
// ************************************************************
`define PBSP_LANES_ALL   4'hf
`define PBSP_LANES_W_BE  4'hc
`define PBSP_LANES_W_LE  4'h3
`define PBSP_LANES_B_BE  4'h8
`define PBSP_LANES_B_LE  4'h1

// ************************************************************
// reset values
// ************************************************************
`define PBSP_RST_WORD    36'h0_0000_0000
`define PBSP_RST_SYNC    88'h00_0000_0000_0000_0000_0000
`define PBSP_RST_MODE    2'h0

`endif

// ---- test/pbsp_ref_pkg.sv ----
// Purpose: reference swap and parity functions for checker and bench
// Assumes: lane 3 is bits 35..27, odd_even_sel high selects odd sense
// Notes:   kept apart from the design so expectations stay independent
package pbsp_ref_pkg;
  function automatic logic [35:0] ref_swap(logic [35:0] w, logic [1:0] m);
    case (m)
      2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: return {w[17:0], w[35:18]};
      2'h3: return {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: return w;
    endcase
  endfunction
  function automatic logic [35:0] ref_gen(logic [35:0] w, logic odd);
    for (int i = 0; i < 4; i++) w[9*i+8] = ^w[9*i +: 8] ^ odd;
    return w;
  endfunction
  // low when any enabled lane fails
  function automatic logic ref_errn(logic [35:0] w, logic odd, logic [3:0] m);
    for (int i = 0; i < 4; i++) m[i] = m[i] & (^w[9*i +: 9] ^ odd);
    return ~|m;
  endfunction
  function automatic logic [3:0] ref_lanes(logic [1:0] sz, logic be_n);
    return sz == 2'h1 ? (be_n ? 4'h3 : 4'hc) : sz == 2'h2 ? (be_n ? 4'h1 : 4'h8) : 4'hf;
  endfunction
  function automatic logic ref_any_swap(logic [35:0] w, logic [35:0] r);
    return w == r || w == ref_swap(r, 2'h1) || w == ref_swap(r, 2'h2) || w == ref_swap(r, 2'h3);
  endfunction
endpackage // pbsp_ref_pkg

// ---- test/pbsp_queue_model.sv ----
// Purpose: queue ram read port on the far side of one core read path
// Assumes: fetch is a one cycle request from the bench
// Notes:   ram data scrambles after the strobe, so a late sample shows
module pbsp_queue_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        fetch,
  input  wire logic [35:0] word,
  output logic      [35:0] rd_data,
  output logic             rd_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data   <= 36'h0;
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= fetch;
      rd_data   <= fetch ? word : ~rd_data;
    end
  end
endmodule // pbsp_queue_model

// ---- test/pbsp_core_properties.sv ----
// Purpose: concurrent checks on the ports of pbsp_core
// Assumes: pins cross a two flop synchroniser before use
// Notes:   pin based checks wait for quiet pins to skip sync latency
module pbsp_core_checker import pbsp_ref_pkg::*; (
  input wire        clock,
  input wire        rstn,
  input wire [35:0] porta_data_in,
  input wire [35:0] portb_data_in,
  input wire        porta_chip_sel_n,
  input wire        porta_xfer_en,
  input wire        porta_write_not_read,
  input wire        porta_mail_sel,
  input wire        porta_parity_gen_sel,
  input wire        portb_chip_sel_n,
  input wire        portb_xfer_en,
  input wire        portb_write_not_read,
  input wire        portb_size_sel_hi,
  input wire        portb_size_sel_lo,
  input wire        portb_big_endian_n,
  input wire        portb_parity_gen_sel,
  input wire        odd_even_sel,
  input wire [35:0] ab_ram_rd_data,
  input wire        ab_ram_rd_strobe,
  input wire [35:0] a_to_b_mail_reg,
  input wire [35:0] b_to_a_mail_reg,
  input wire [35:0] ba_assembled_word,
  input wire        ba_ram_wr_strobe,
  input wire [35:0] portb_data_out,
  input wire [35:0] porta_data_out,
  input wire [35:0] ba_ram_wr_data,
  input wire        ba_ram_wr_valid,
  input wire        porta_parity_err_n,
  input wire        portb_parity_err_n
);
  wire [84:0] pins = {porta_data_in, portb_data_in, odd_even_sel, porta_chip_sel_n,
                      porta_xfer_en, porta_write_not_read, porta_mail_sel, porta_parity_gen_sel,
                      portb_chip_sel_n, portb_xfer_en, portb_write_not_read, portb_size_sel_hi,
                      portb_size_sel_lo, portb_big_endian_n, portb_parity_gen_sel};
  reg  [84:0] pin_ff;
  reg  [2:0]  calm_ff;
  wire        calm = calm_ff >= 3'h4 && pins == pin_ff;
  wire        a_rd = !porta_chip_sel_n && porta_xfer_en && !porta_write_not_read && porta_mail_sel;
  wire        b_rd = !portb_chip_sel_n && portb_xfer_en && !portb_write_not_read &&
                     portb_size_sel_hi && portb_size_sel_lo;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_ff  <= 85'h0;
      calm_ff <= 3'h0;
    end else begin
      pin_ff  <= pins;
      calm_ff <= (pins != pin_ff) ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h7};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_erra_value: assert property (calm |-> porta_parity_err_n ==
    (a_rd && porta_parity_gen_sel || ref_errn(porta_data_in, odd_even_sel, 4'hf)))
    else $error("port a flag wrong");
  a_errb_value: assert property (calm |-> portb_parity_err_n ==
    (b_rd && portb_parity_gen_sel || ref_errn(portb_data_in, odd_even_sel,
     ref_lanes({portb_size_sel_hi, portb_size_sel_lo}, portb_big_endian_n))))
    else $error("port b flag wrong");
  a_rd_swap_whole: assert property (
    ab_ram_rd_strobe && calm && portb_chip_sel_n && !portb_parity_gen_sel
    |=> ref_any_swap(portb_data_out, $past(ab_ram_rd_data))) else $error("read not a swap");
  a_rd_gen_parity: assert property (
    ab_ram_rd_strobe && calm && portb_chip_sel_n && portb_parity_gen_sel
    |=> portb_data_out == ref_gen(portb_data_out, $past(odd_even_sel)))
    else $error("generated bit wrong");
  a_mail_a_plain: assert property (calm && a_rd && !porta_parity_gen_sel
    |=> porta_data_out == $past(b_to_a_mail_reg)) else $error("port a mail wrong");
  a_mail_b_plain: assert property (calm && b_rd && !portb_parity_gen_sel
    |=> portb_data_out == $past(a_to_b_mail_reg)) else $error("port b mail wrong");
  a_wr_valid_pulse: assert property (
    ba_ram_wr_valid == $past(ba_ram_wr_strobe)) else $error("commit valid wrong");
  a_wr_bytes_whole: assert property (
    ba_ram_wr_valid |-> ref_any_swap(ba_ram_wr_data, $past(ba_assembled_word)))
    else $error("commit not a swap");
endmodule // pbsp_core_checker
bind pbsp_core pbsp_core_checker u_pbsp_core_checker (.*);

// ---- test/tb_port_byte_swap_parity.sv ----
// Purpose: self checking bench for pbsp_core
// Assumes: pins take two edges through the synchroniser, so checks wait
// Notes:   random words and selects from a fixed seed
module tb_port_byte_swap_parity import pbsp_ref_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        fetch = 1'b0;
  logic [35:0] word, porta_data_in, portb_data_in, a_to_b_mail_reg, b_to_a_mail_reg;
  logic [35:0] ba_assembled_word, exp;
  wire  [35:0] portb_data_out, porta_data_out, ba_ram_wr_data, ab_ram_rd_data, ba_ram_rd_data;
  wire         ba_ram_wr_valid, porta_parity_err_n, portb_parity_err_n;
  wire         ab_ram_rd_strobe, ba_ram_rd_strobe;
  logic        porta_chip_sel_n, porta_xfer_en, porta_write_not_read, porta_mail_sel;
  logic        porta_parity_gen_sel, portb_chip_sel_n, portb_xfer_en, portb_write_not_read;
  logic        portb_size_sel_hi, portb_size_sel_lo, portb_big_endian_n, portb_parity_gen_sel;
  logic        swap_sel_hi, swap_sel_lo, odd_even_sel, ba_word_start, ba_ram_wr_strobe, odd;
  int          error_cnt = 0;
  int          n_checks = 0;
  pbsp_core u_pbsp_core (.*);
  pbsp_queue_model u_pbsp_queue_model (.clock(clock), .rstn(rstn), .fetch(fetch),
    .word(word), .rd_data(ab_ram_rd_data), .rd_strobe(ab_ram_rd_strobe));
  pbsp_queue_model u_pbsp_queue_model_ba (.clock(clock), .rstn(rstn), .fetch(fetch),
    .word(word), .rd_data(ba_ram_rd_data), .rd_strobe(ba_ram_rd_strobe));
  always #5 clock = ~clock;
  task automatic chk(string what, logic [35:0] seen, logic [35:0] expv);
    n_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    error_cnt++;
    conclude();
  end
  initial begin
    int k, g;
    {word, porta_data_in, portb_data_in, a_to_b_mail_reg, b_to_a_mail_reg} = '0;
    {ba_assembled_word, porta_xfer_en, porta_write_not_read, porta_mail_sel} = '0;
    {porta_parity_gen_sel, portb_xfer_en, portb_write_not_read, portb_size_sel_hi} = '0;
    {portb_size_sel_lo, portb_big_endian_n, portb_parity_gen_sel, swap_sel_hi} = '0;
    {swap_sel_lo, odd_even_sel, ba_word_start, ba_ram_wr_strobe} = '0;
    {porta_chip_sel_n, portb_chip_sel_n} = 2'h3;
    void'($urandom(32'h5a92));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    // queue reads: every swap code, parity generated or not, selects moved after load
    for (k = 0; k < 8; k++) begin
      @(posedge clock);
      {swap_sel_hi, swap_sel_lo} <= k[2:1];
      portb_parity_gen_sel <= k[0];
      porta_parity_gen_sel <= k[0];
      odd_even_sel <= 1'($urandom);
      word <= 36'({$urandom, $urandom});
      cyc(4);
      @(posedge clock) fetch <= 1'b1;
      @(posedge clock) fetch <= 1'b0;
      exp = k[0] ? ref_gen(ref_swap(word, k[2:1]), odd_even_sel) : ref_swap(word, k[2:1]);
      for (g = 0; g < 2; g++) begin
        cyc(4);
        chk("portb_data_out", portb_data_out, exp);
        chk("porta_data_out", porta_data_out, k[0] ? ref_gen(word, odd_even_sel) : word);
        @(posedge clock);
        {swap_sel_hi, swap_sel_lo} <= ~k[2:1];
        portb_parity_gen_sel <= ~k[0];
        porta_parity_gen_sel <= ~k[0];
        odd = odd_even_sel;
      end
    end
    // commits: swap latched at the first unit, selects changed before commit
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      {swap_sel_hi, swap_sel_lo} <= k[1:0];
      ba_assembled_word <= 36'({$urandom, $urandom});
      cyc(3);
      @(posedge clock) ba_word_start <= 1'b1;
      @(posedge clock) begin
        ba_word_start <= 1'b0;
        {swap_sel_hi, swap_sel_lo} <= ~k[1:0];
      end
      cyc(3);
      @(posedge clock) ba_ram_wr_strobe <= 1'b1;
      @(posedge clock) ba_ram_wr_strobe <= 1'b0;
      #1;
      chk("ba_ram_wr_valid", ba_ram_wr_valid, 1'b1);
      chk("ba_ram_wr_data", ba_ram_wr_data, ref_swap(ba_assembled_word, k[1:0]));
    end
    // mail reads on both ports with a bad byte on the bus
    for (g = 0; g < 2; g++) begin
      odd = 1'($urandom);
      @(posedge clock);
      {porta_chip_sel_n, porta_xfer_en, porta_mail_sel, porta_parity_gen_sel} <= {3'h3, g[0]};
      {portb_chip_sel_n, portb_xfer_en, portb_size_sel_hi, portb_size_sel_lo} <= 4'h7;
      portb_parity_gen_sel <= g[0];
      odd_even_sel <= odd;
      porta_data_in <= {35'h0, !odd};
      portb_data_in <= {35'h0, !odd};
      a_to_b_mail_reg <= 36'({$urandom, $urandom});
      b_to_a_mail_reg <= 36'({$urandom, $urandom});
      cyc(5);
      exp = g ? ref_gen(b_to_a_mail_reg, odd) : b_to_a_mail_reg;
      chk("porta_data_out", porta_data_out, exp);
      exp = g ? ref_gen(a_to_b_mail_reg, odd) : a_to_b_mail_reg;
      chk("portb_data_out", portb_data_out, exp);
      chk("porta_parity_err_n", porta_parity_err_n, g[0]);
      chk("portb_parity_err_n", portb_parity_err_n, g[0]);
    end
    @(posedge clock);
    {porta_chip_sel_n, portb_chip_sel_n} <= 2'h3;
    // random bus levels, sizes, endianness and sense
    for (k = 0; k < 24; k++) begin
      @(posedge clock);
      porta_data_in <= 36'({$urandom, $urandom});
      portb_data_in <= 36'({$urandom, $urandom});
      {portb_size_sel_hi, portb_size_sel_lo, portb_big_endian_n, odd_even_sel} <= 4'($urandom);
      cyc(5);
      exp[0] = ref_errn(porta_data_in, odd_even_sel, 4'hf);
      chk("porta_parity_err_n", porta_parity_err_n, exp[0]);
      exp[3:0] = ref_lanes({portb_size_sel_hi, portb_size_sel_lo}, portb_big_endian_n);
      exp[0] = ref_errn(portb_data_in, odd_even_sel, exp[3:0]);
      chk("portb_parity_err_n", portb_parity_err_n, exp[0]);
    end
    conclude();
  end
endmodule // tb_port_byte_swap_parity
